// *** logic/ait_pkg.sv ***
/*
 * Constants, states and the state record of the arithmetic execution block.
 * Assumes a single system clock; time figures are given in system clock cycles.
 */
package ait_pkg;

    // ------------------------------------------------------------------
    // Opcode fields
    // ------------------------------------------------------------------
    localparam logic [3:0] OPC_ADD        = 4'h2;
    localparam logic [3:0] OPC_ADD_WITH_CARRY       = 4'h3;
    localparam logic [3:0] OPC_SUBTRACT_WITH_BORROW       = 4'h9;
    localparam logic [3:0] MODE_IMM       = 4'h4;
    localparam logic [3:0] MODE_DIRECT    = 4'h5;
    localparam logic [2:0] MODE_INDIRECT  = 3'h3;  // Low nibble 6 or 7
    localparam logic [7:0] ACC_SFR_ADDR   = 8'hE0;
    localparam logic [7:0] BIT_RAM_BASE   = 8'h20;

    // ------------------------------------------------------------------
    // Instruction lengths and cycle counts
    // ------------------------------------------------------------------
    localparam logic [1:0] LEN_REG        = 2'h1;
    localparam logic [1:0] LEN_DIRECT     = 2'h2;
    localparam logic [1:0] LEN_INDIRECT   = 2'h1;
    localparam logic [1:0] LEN_IMM        = 2'h2;
    localparam logic [2:0] CYC_REG        = 3'h2;
    localparam logic [2:0] CYC_DIRECT     = 3'h3;
    localparam logic [2:0] CYC_INDIRECT   = 3'h3;
    localparam logic [2:0] CYC_IMM        = 3'h2;

    // ------------------------------------------------------------------
    // Branch target kinds
    // ------------------------------------------------------------------
    localparam logic [1:0] TGT_REL        = 2'h0;
    localparam logic [1:0] TGT_PAGE       = 2'h1;
    localparam logic [1:0] TGT_LONG       = 2'h2;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  ACC_RST       = 8'h00;
    localparam logic [15:0] TGT_RST       = 16'h0000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PTR  = 2'b01,
        ST_WAIT = 2'b10,
        ST_EXEC = 2'b11
    } ait_state_t;

    typedef struct packed {
        ait_state_t  st;
        logic [1:0]  op;        // 0 add, 1 add_with_carry, 2 subtract_with_borrow
        logic        imm;
        logic        acc_sel;   // Direct operand is the accumulator itself
        logic [7:0]  opnd;
        logic [1:0]  len;
        logic [2:0]  cyc;
        logic [7:0]  mem_addr;
        logic        mem_sfr;
        logic        mem_rd;
        logic [7:0]  acc;
        logic        cy;
        logic        ac;
        logic        ov;
        logic        busy;
        logic        done;
        logic [1:0]  len_out;
        logic [2:0]  cyc_out;
        logic [15:0] tgt;
        logic        tgt_vld;
        logic [7:0]  bit_byte;
        logic [2:0]  bit_idx;
        logic        bit_sfr;
        logic        bit_vld;
        logic [15:0] imm16;
    } ait_state_rec_t;

endpackage

// *** logic/ait_exec.sv ***
/*
 * Arithmetic execution unit: add, add_with_carry and subtract_with_borrow
 * with register, direct, indirect and immediate operands, plus operand
 * decoding for branch targets, bit operands and sixteen-bit immediates.
 * Assumes a data memory with combinational read data, valid in the
 * same cycle that the registered mem_addr is presented.
 */
`timescale 1ns/1ps
`default_nettype none
module ait_exec (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic        clk_en,
    // Instruction issue
    input  wire logic        instr_valid,
    input  wire logic [7:0]  instr_opcode,
    input  wire logic [7:0]  instr_byte1,
    input  wire logic [7:0]  instr_byte2,
    input  wire logic [1:0]  bank_sel,
    // Accumulator and carry load from other instructions
    input  wire logic        acc_load,
    input  wire logic [7:0]  acc_load_data,
    input  wire logic        cy_load,
    input  wire logic        cy_load_data,
    // Data memory read
    input  wire logic [7:0]  mem_rd_data,
    output logic             mem_rd,
    output logic [7:0]       mem_addr,
    output logic             mem_sfr,
    // Arithmetic results
    output logic             busy,
    output logic             done,
    output logic [1:0]       instr_len,
    output logic [2:0]       instr_cycles,
    output logic [7:0]       acc,
    output logic             flag_cy,
    output logic             flag_ac,
    output logic             flag_ov,
    // Branch target and immediate decode
    input  wire logic        tgt_req,
    input  wire logic [1:0]  tgt_kind,
    input  wire logic [15:0] next_pc,
    output logic             tgt_valid,
    output logic [15:0]      tgt_addr,
    output logic [15:0]      imm16_operand,
    // Bit operand decode
    input  wire logic        bit_req,
    input  wire logic [7:0]  bit_operand,
    output logic             bit_valid,
    output logic [7:0]       bit_byte_addr,
    output logic [2:0]       bit_index,
    output logic             bit_sfr
);

    ait_pkg::ait_state_rec_t s_q;
    ait_pkg::ait_state_rec_t s_d;

    logic [8:0] res9;
    logic [4:0] res5;
    logic [7:0] rhs;
    logic       cin;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        s_d.tgt_vld = 1'b0;
        s_d.bit_vld = 1'b0;
        s_d.mem_rd = 1'b0;
        rhs = s_q.opnd;
        // Direct address E0 is the accumulator, which the memory port cannot return
        if (s_q.st == ait_pkg::ST_EXEC && !s_q.imm) begin
            rhs = s_q.acc_sel ? s_q.acc : mem_rd_data;
        end
        cin = (s_q.op == 2'h0) ? 1'b0 : s_q.cy;
        // Subtraction works on the borrow sense of the nine-bit result
        if (s_q.op == 2'h2) begin
            res9 = {1'b0, s_q.acc} - {1'b0, rhs} - {8'h00, cin};
            res5 = {1'b0, s_q.acc[3:0]} - {1'b0, rhs[3:0]} - {4'h0, cin};
        end else begin
            res9 = {1'b0, s_q.acc} + {1'b0, rhs} + {8'h00, cin};
            res5 = {1'b0, s_q.acc[3:0]} + {1'b0, rhs[3:0]} + {4'h0, cin};
        end

        unique case (s_q.st)
            ait_pkg::ST_IDLE: begin
                if (instr_valid && (instr_opcode[7:4] == ait_pkg::OPC_ADD
                        || instr_opcode[7:4] == ait_pkg::OPC_ADD_WITH_CARRY
                        || instr_opcode[7:4] == ait_pkg::OPC_SUBTRACT_WITH_BORROW)) begin
                    s_d.busy = 1'b1;
                    s_d.op = (instr_opcode[7:4] == ait_pkg::OPC_ADD) ? 2'h0 :
                             (instr_opcode[7:4] == ait_pkg::OPC_ADD_WITH_CARRY) ? 2'h1 : 2'h2;
                    s_d.imm = 1'b0;
                    s_d.acc_sel = 1'b0;
                    s_d.mem_sfr = 1'b0;
                    if (instr_opcode[3]) begin
                        s_d.mem_addr = {3'h0, bank_sel, instr_opcode[2:0]};
                        s_d.mem_rd = 1'b1;
                        s_d.len = ait_pkg::LEN_REG;
                        s_d.cyc = ait_pkg::CYC_REG;
                        s_d.st = ait_pkg::ST_EXEC;
                    end else if (instr_opcode[3:1] == ait_pkg::MODE_INDIRECT) begin
                        s_d.mem_addr = {3'h0, bank_sel, 2'h0, instr_opcode[0]};
                        s_d.mem_rd = 1'b1;
                        s_d.len = ait_pkg::LEN_INDIRECT;
                        s_d.cyc = ait_pkg::CYC_INDIRECT;
                        s_d.st = ait_pkg::ST_PTR;
                    end else if (instr_opcode[3:0] == ait_pkg::MODE_DIRECT) begin
                        s_d.mem_addr = instr_byte1;
                        s_d.mem_sfr = instr_byte1[7];
                        s_d.mem_rd = 1'b1;
                        s_d.acc_sel = (instr_byte1 == ait_pkg::ACC_SFR_ADDR);
                        s_d.len = ait_pkg::LEN_DIRECT;
                        s_d.cyc = ait_pkg::CYC_DIRECT;
                        s_d.st = ait_pkg::ST_WAIT;
                    end else if (instr_opcode[3:0] == ait_pkg::MODE_IMM) begin
                        s_d.opnd = instr_byte1;
                        s_d.imm = 1'b1;
                        s_d.len = ait_pkg::LEN_IMM;
                        s_d.cyc = ait_pkg::CYC_IMM;
                        s_d.st = ait_pkg::ST_EXEC;
                    end else begin
                        s_d.busy = 1'b0;
                    end
                end
            end
            ait_pkg::ST_PTR: begin
                // Pointer byte is back; it addresses internal RAM, never the SFRs
                s_d.mem_addr = mem_rd_data;
                s_d.mem_sfr = 1'b0;
                s_d.mem_rd = 1'b1;
                s_d.st = ait_pkg::ST_EXEC;
            end
            ait_pkg::ST_WAIT: begin
                // Extra cycle gives the SFR space its access time
                s_d.st = ait_pkg::ST_EXEC;
            end
            ait_pkg::ST_EXEC: begin
                s_d.acc = res9[7:0];
                s_d.cy = res9[8];
                s_d.ac = res5[4];
                // Overflow is read from the signs alone, so no carry into bit seven is kept
                if (s_q.op == 2'h2) begin
                    s_d.ov = (s_q.acc[7] ^ rhs[7]) & (s_q.acc[7] ^ res9[7]);
                end else begin
                    s_d.ov = (s_q.acc[7] ~^ rhs[7]) & (s_q.acc[7] ^ res9[7]);
                end
                s_d.done = 1'b1;
                s_d.busy = 1'b0;
                s_d.len_out = s_q.len;
                s_d.cyc_out = s_q.cyc;
                s_d.st = ait_pkg::ST_IDLE;
            end
        endcase

        // External loads only land while no arithmetic is in flight
        if (s_q.st == ait_pkg::ST_IDLE) begin
            if (acc_load) begin
                s_d.acc = acc_load_data;
            end
            if (cy_load) begin
                s_d.cy = cy_load_data;
            end
        end

        if (tgt_req) begin
            s_d.tgt_vld = 1'b1;
            s_d.imm16 = {instr_byte1, instr_byte2};
            unique case (tgt_kind)
                ait_pkg::TGT_PAGE:
                    s_d.tgt = {next_pc[15:11], instr_opcode[7:5], instr_byte1};
                ait_pkg::TGT_LONG:
                    s_d.tgt = {instr_byte1, instr_byte2};
                default:
                    s_d.tgt = next_pc + {{8{instr_byte1[7]}}, instr_byte1};
            endcase
        end

        if (bit_req) begin
            s_d.bit_vld = 1'b1;
            s_d.bit_idx = bit_operand[2:0];
            s_d.bit_sfr = bit_operand[7];
            s_d.bit_byte = bit_operand[7] ? {bit_operand[7:3], 3'h0}
                                          : ait_pkg::BIT_RAM_BASE + {4'h0, bit_operand[6:3]};
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
            s_q.st <= ait_pkg::ST_IDLE;
            s_q.acc <= ait_pkg::ACC_RST;
            s_q.tgt <= ait_pkg::TGT_RST;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign mem_rd        = s_q.mem_rd;
    assign mem_addr      = s_q.mem_addr;
    assign mem_sfr       = s_q.mem_sfr;
    assign busy          = s_q.busy;
    assign done          = s_q.done;
    assign instr_len     = s_q.len_out;
    assign instr_cycles  = s_q.cyc_out;
    assign acc           = s_q.acc;
    assign flag_cy       = s_q.cy;
    assign flag_ac       = s_q.ac;
    assign flag_ov       = s_q.ov;
    assign tgt_valid     = s_q.tgt_vld;
    assign tgt_addr      = s_q.tgt;
    assign imm16_operand = s_q.imm16;
    assign bit_valid     = s_q.bit_vld;
    assign bit_byte_addr = s_q.bit_byte;
    assign bit_index     = s_q.bit_idx;
    assign bit_sfr       = s_q.bit_sfr;

endmodule
`default_nettype wire

// *** dv/ait_exec_sva.sv ***
/*
 * Port checker for the arithmetic execution block, bound to its top module.
 * Assumes clk_en stays high while an instruction or a decode is in flight.
 */
`timescale 1ns/1ps
`default_nettype none
module ait_exec_sva (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        arst_n,
    input wire logic        clk_en,
    // Requests
    input wire logic        instr_valid,
    input wire logic [7:0]  instr_opcode,
    input wire logic [7:0]  instr_byte1,
    input wire logic [7:0]  instr_byte2,
    input wire logic [1:0]  bank_sel,
    input wire logic        tgt_req,
    input wire logic [1:0]  tgt_kind,
    input wire logic [15:0] next_pc,
    // Answers
    input wire logic        busy,
    input wire logic        done,
    input wire logic [1:0]  instr_len,
    input wire logic [2:0]  instr_cycles,
    input wire logic        mem_rd,
    input wire logic [7:0]  mem_addr,
    input wire logic        mem_sfr,
    input wire logic        tgt_valid,
    input wire logic [15:0] tgt_addr
);
    typedef struct packed {
        logic [15:0] pc;
        logic [7:0]  op;
        logic [7:0]  b1;
        logic [7:0]  b2;
        logic [1:0]  bank;
    } ait_cap_t;
    ait_cap_t cap_q;
    ait_cap_t cap_d;
    logic     take;

    // Request fields are kept one cycle so answers can be tied to them
    assign take = clk_en && !busy && instr_valid && instr_opcode[3:0] >= 4'h4
        && (instr_opcode[7:4] inside {4'h2, 4'h3, 4'h9});
    always_comb cap_d = {next_pc, instr_opcode, instr_byte1, instr_byte2, bank_sel};
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n)
            cap_q <= '0;
        else
            cap_q <= cap_d;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    a_reg_two_cycles: assert property (take && instr_opcode[3] |=> !done ##1 done && instr_len == 2'h1 && instr_cycles == 3'h2)
        else $error("register op timing wrong");
    a_mem_three_cycles: assert property (take && instr_opcode[3:2] == 2'h1 && instr_opcode[1:0] != 2'h0 |=> !done [*2] ##1 done && instr_cycles == 3'h3)
        else $error("memory op timing wrong");
    a_imm_two_cycles: assert property (take && instr_opcode[3:0] == 4'h4 |=> !done ##1 done && instr_len == 2'h2 && instr_cycles == 3'h2)
        else $error("immediate op timing wrong");
    a_done_single_pulse: assert property (done && clk_en |-> !busy ##1 !done)
        else $error("done not a single idle pulse");
    a_reg_bank_addr: assert property (take && instr_opcode[3] |=> mem_rd && mem_addr == {3'h0, cap_q.bank, cap_q.op[2:0]})
        else $error("register address wrong");
    a_ptr_reg_addr: assert property (take && instr_opcode[3:1] == 3'h3 |=> mem_rd && mem_addr == {3'h0, cap_q.bank, 2'h0, cap_q.op[0]} ##1 !mem_sfr)
        else $error("pointer fetch wrong");
    a_sfr_space: assert property (mem_sfr |-> mem_addr[7])
        else $error("special space below 0x80");
    a_long_target: assert property (tgt_req && clk_en && tgt_kind == 2'h2 |=> tgt_valid && tgt_addr == {cap_q.b1, cap_q.b2})
        else $error("long target wrong");
    a_page_target: assert property (tgt_req && clk_en && tgt_kind == 2'h1 |=> tgt_addr == {cap_q.pc[15:11], cap_q.op[7:5], cap_q.b1})
        else $error("page target wrong");
    a_rel_target: assert property (tgt_req && clk_en && tgt_kind == 2'h0 |=> tgt_addr == cap_q.pc + {{8{cap_q.b1[7]}}, cap_q.b1})
        else $error("relative target wrong");
    a_direct_addr: assert property (take && instr_opcode[3:0] == 4'h5 |=> mem_rd && mem_addr == cap_q.b1 && mem_sfr == cap_q.b1[7])
        else $error("direct address or space wrong");
    a_busy_bounded: assert property (busy |-> ##[1:5] !busy)
        else $error("instruction longer than six cycles");
endmodule

bind ait_exec ait_exec_sva chk_u (.clk_sys, .arst_n, .clk_en, .instr_valid, .instr_opcode, .instr_byte1, .instr_byte2,
    .bank_sel, .tgt_req, .tgt_kind, .next_pc, .busy, .done, .instr_len, .instr_cycles, .mem_rd, .mem_addr, .mem_sfr,
    .tgt_valid, .tgt_addr);
`default_nettype wire

// *** dv/testbench.sv ***
/*
 * Self-checking bench for the arithmetic execution block.
 * Assumes a combinational data memory answering mem_addr; drivers queue notes, monitors compare.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk_sys, arst_n, clk_en, instr_valid, acc_load, cy_load, cy_load_data, tgt_req, bit_req;
    logic [7:0]  instr_opcode, instr_byte1, instr_byte2, acc_load_data, mem_rd_data, bit_operand, mem_addr, acc;
    logic [7:0]  bit_byte_addr, acc_m, mem [256];
    logic [1:0]  bank_sel, tgt_kind, instr_len;
    logic [15:0] next_pc, tgt_addr, imm16_operand;
    logic [2:0]  instr_cycles, bit_index;
    logic        mem_rd, mem_sfr, busy, done, flag_cy, flag_ac, flag_ov, tgt_valid, bit_valid, bit_sfr;
    logic [31:0] eq_a[$], eq_t[$], eq_b[$];
    int          err_count, cmp_count, seed = 71830;

    assign mem_rd_data = mem[mem_addr];
    ait_exec dut_u (.clk_sys, .arst_n, .clk_en, .instr_valid, .instr_opcode, .instr_byte1, .instr_byte2, .bank_sel,
        .acc_load, .acc_load_data, .cy_load, .cy_load_data, .mem_rd_data, .mem_rd, .mem_addr, .mem_sfr, .busy, .done,
        .instr_len, .instr_cycles, .acc, .flag_cy, .flag_ac, .flag_ov, .tgt_req, .tgt_kind, .next_pc, .tgt_valid,
        .tgt_addr, .imm16_operand, .bit_req, .bit_operand, .bit_valid, .bit_byte_addr, .bit_index, .bit_sfr);

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        // Notes never answered mean a result went missing
        if (eq_a.size() + eq_t.size() + eq_b.size() != 0)
            err_count++;
        $display("errors %0d comparisons %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Loads acc and carry first, then issues one instruction
    task automatic arith(input logic [7:0] opc, input logic [7:0] a, input logic c, input logic [7:0] b1);
        logic [7:0] src;
        logic [8:0] w;
        logic       ci, ac, ov;
        logic [1:0] bk;
        int         n;
        bk = 2'($random(seed));
        case (opc[3:0])
            4'h4: src = b1;
            4'h5: src = (b1 == 8'hE0) ? a : mem[b1];
            4'h6, 4'h7: src = mem[mem[{3'h0, bk, 2'h0, opc[0]}]];
            default: src = mem[{3'h0, bk, opc[2:0]}];
        endcase
        ci = (opc[7:4] == 4'h2) ? 1'b0 : c;
        if (opc[7:4] == 4'h9) begin
            w = {1'b0, a} - {1'b0, src} - 9'(ci);
            ac = 5'(a[3:0]) < 5'(src[3:0]) + 5'(ci);
            ov = (a[7] != src[7]) && (w[7] != a[7]);
        end else begin
            w = {1'b0, a} + {1'b0, src} + 9'(ci);
            ac = 5'(a[3:0]) + 5'(src[3:0]) + 5'(ci) > 5'h0F;
            ov = (a[7] == src[7]) && (w[7] != a[7]);
        end
        eq_a.push_back(32'({(opc[3:1] == 3'h2) ? 2'h2 : 2'h1,
            (opc[3:2] == 2'h1 && opc[1:0] != 2'h0) ? 3'h3 : 3'h2, w[8], ac, ov, w[7:0]}));
        @(posedge clk_sys);
        acc_load <= 1'b1;
        acc_load_data <= a;
        cy_load <= 1'b1;
        cy_load_data <= c;
        @(posedge clk_sys);
        acc_load <= 1'b0;
        cy_load <= 1'b0;
        instr_valid <= 1'b1;
        instr_opcode <= opc;
        instr_byte1 <= b1;
        bank_sel <= bk;
        @(posedge clk_sys);
        instr_valid <= 1'b0;
        for (n = 0; n < 8 && done !== 1'b1; n++)
            @(negedge clk_sys);
        if (n == 8) begin
            err_count++;
            stop_test;
        end
        acc_m = w[7:0];
    endtask

    // One target and one bit request per edge, back to back
    task automatic dec(input logic [1:0] k, input logic [15:0] pc, input logic [7:0] op, b1, b2, bo);
        eq_t.push_back({k == 2'h2 ? {b1, b2} : k == 2'h1 ? {pc[15:11], op[7:5], b1} : pc + {{8{b1[7]}}, b1}, b1, b2});
        eq_b.push_back(32'({bo[7], bo[7] ? bo & 8'hF8 : 8'h20 + 8'(bo[6:3]), bo[2:0]}));
        @(posedge clk_sys);
        tgt_req <= 1'b1;
        tgt_kind <= k;
        next_pc <= pc;
        instr_opcode <= op;
        instr_byte1 <= b1;
        instr_byte2 <= b2;
        bit_req <= 1'b1;
        bit_operand <= bo;
    endtask

    always @(negedge clk_sys) begin
        if (done === 1'b1)
            check({instr_len, instr_cycles, flag_cy, flag_ac, flag_ov, acc}, eq_a.pop_front());
        if (tgt_valid === 1'b1)
            check({tgt_addr, imm16_operand}, eq_t.pop_front());
        if (bit_valid === 1'b1)
            check({bit_sfr, bit_byte_addr, bit_index}, eq_b.pop_front());
    end

    initial begin
        logic [7:0] b;
        {arst_n, instr_valid, acc_load, cy_load, cy_load_data, tgt_req, bit_req} = '0;
        {instr_opcode, instr_byte1, instr_byte2, acc_load_data, bit_operand, bank_sel, tgt_kind, next_pc} = '0;
        clk_en = 1'b1;
        for (int i = 0; i < 256; i++)
            mem[i] = 8'($random(seed));
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        arith(8'h24, 8'h7F, 1'b1, 8'h01);
        arith(8'h94, 8'h00, 1'b1, 8'h00);
        arith(8'h35, 8'h5A, 1'b1, 8'hE0);
        for (int i = 0; i < 72; i++) begin
            b = 8'($random(seed));
            // Address E0 is the accumulator itself; kept out of the memory model
            if (b == 8'hE0)
                b = 8'hE1;
            arith({i % 3 == 0 ? 4'h2 : i % 3 == 1 ? 4'h3 : 4'h9, 4'(4 + (i / 3) % 12)}, 8'($random(seed)),
                1'($random(seed)), b);
        end
        @(posedge clk_sys);
        instr_valid <= 1'b1;
        instr_opcode <= 8'h23;
        @(posedge clk_sys);
        instr_valid <= 1'b0;
        @(negedge clk_sys);
        check(busy, 32'h0);
        @(posedge clk_sys);
        clk_en <= 1'b0;
        acc_load <= 1'b1;
        acc_load_data <= ~acc_m;
        repeat (3) @(posedge clk_sys);
        clk_en <= 1'b1;
        acc_load <= 1'b0;
        @(negedge clk_sys);
        check(acc, acc_m);
        dec(2'h0, 16'h0005, 8'h00, 8'h80, 8'h00, 8'h7F);
        dec(2'h0, 16'hFFF0, 8'h00, 8'h7F, 8'h00, 8'h80);
        for (int i = 0; i < 40; i++)
            dec(2'($unsigned($random(seed)) % 3), 16'($random(seed)), 8'($random(seed)), 8'($random(seed)),
                8'($random(seed)), 8'($random(seed)));
        @(posedge clk_sys);
        tgt_req <= 1'b0;
        bit_req <= 1'b0;
        repeat (3) @(negedge clk_sys);
        stop_test;
    end
endmodule
`default_nettype wire
